// [hdl/dual_timebase_capture_compare.sv]
// Purpose: 32-channel capture/compare unit with two timer pairs
// Assumes: AHB-Lite slave, zero wait states; pins synchronous
// Notes:   interrupt requests leave as one-cycle pulses
//
// Register access over AHB-Lite and the address map were decided locally.
`timescale 1ns/100ps
`include "capture_compare_unit_consts.svh"
module dual_timebase_capture_compare (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic [31:0] cc_pin_in,
    output logic      [31:0] cc_pin_out,
    output logic      [31:0] cc_pin_oe,
    input  wire logic        ext_count_a,
    input  wire logic        ext_count_b,
    input  wire logic        gp_timer_six_ovf,
    output logic      [31:0] ch_irq,
    output logic      [3:0]  tmr_irq
);
    localparam int NCH = 32;
    localparam int NTM = 4;

    function automatic logic is_cmp(input capture_compare_unit_pkg::mode_t m);
        is_cmp = m[2];
    endfunction

    function automatic logic is_cap(input capture_compare_unit_pkg::mode_t m);
        is_cap = (m != `CC_MODE_OFF) && !m[2];
    endfunction

    // ---------------- bus slave ----------------
    logic        wr_pend_r;
    logic [11:0] wr_addr_r;
    logic [31:0] hrdata_r;

    wire         addr_ok  = (haddr[31:12] == 20'h0_0000);
    wire         req      = hsel & htrans[1] & hready;
    wire [11:0]  a        = haddr[11:0];
    wire [4:0]   rch      = a[6:2];
    wire [1:0]   rtm      = a[3:2];

    // channel and timer storage
    capture_compare_unit_pkg::count_t ch_val_r [NCH];
    logic [4:0]         ch_ctl_r [NCH];
    logic [3:0]         tm_ctl_r [NTM];
    capture_compare_unit_pkg::count_t tm_cnt   [NTM];
    capture_compare_unit_pkg::count_t tm_rld   [NTM];
    logic [NTM-1:0]     tm_step;
    logic [NTM-1:0]     tm_ovf;
    logic [NCH-1:0]     pin_r;
    logic [NCH-1:0]     oe_r;
    logic [NCH-1:0]     pin_in_d_r;
    logic [NCH-1:0]     fired_r;
    logic [NCH-1:0]     irq_r;
    logic [NTM-1:0]     tirq_r;

    wire sel_ch_val = addr_ok && a[11:7] == 5'h00;
    wire sel_ch_ctl = addr_ok && a[11:7] == 5'h01;
    wire sel_cnt    = addr_ok && a[11:4] == `CC_TMR_CNT_BASE >> 4;
    wire sel_rld    = addr_ok && a[11:4] == `CC_TMR_RLD_BASE >> 4;
    wire sel_tctl   = addr_ok && a[11:4] == `CC_TMR_CTL_BASE >> 4;
    wire sel_pst    = addr_ok && a == `CC_PIN_STATE;
    wire sel_pin    = addr_ok && a == `CC_PIN_INPUT;

    // unmapped addresses read as zero, writes dropped
    wire [31:0] rd_data =
        sel_ch_val ? {16'h0000, ch_val_r[rch]} :
        sel_ch_ctl ? {27'h000_0000, ch_ctl_r[rch]} :
        sel_cnt    ? {16'h0000, tm_cnt[rtm]} :
        sel_rld    ? {16'h0000, tm_rld[rtm]} :
        sel_tctl   ? {28'h000_0000, tm_ctl_r[rtm]} :
        sel_pst    ? pin_r :
        sel_pin    ? cc_pin_in : 32'h0000_0000;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 12'h000;
            hrdata_r  <= 32'h0000_0000;
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
        end else begin
            wr_pend_r <= req & hwrite & addr_ok;
            wr_addr_r <= a;
            if (req & ~hwrite) begin
                hrdata_r <= rd_data;
            end
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end
    assign hrdata = hrdata_r;

    wire [4:0] wch = wr_addr_r[6:2];
    wire [1:0] wtm = wr_addr_r[3:2];
    wire wr_val  = wr_pend_r && wr_addr_r[11:7] == 5'h00;
    wire wr_ctl  = wr_pend_r && wr_addr_r[11:7] == 5'h01;
    wire wr_cnt  = wr_pend_r && wr_addr_r[11:4] == `CC_TMR_CNT_BASE >> 4;
    wire wr_rld  = wr_pend_r && wr_addr_r[11:4] == `CC_TMR_RLD_BASE >> 4;
    wire wr_tctl = wr_pend_r && wr_addr_r[11:4] == `CC_TMR_CTL_BASE >> 4;

    // ---------------- clock sources ----------------
    logic [`CC_PRE_W-1:0] pre_r;
    logic [1:0]           ext_d_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pre_r   <= '0;
            ext_d_r <= 2'b00;
        end else begin
            pre_r   <= pre_r + 1'b1;
            ext_d_r <= {ext_count_b, ext_count_a};
        end
    end

    // external count edges, pairs a and b
    wire [1:0] ext_rise = {ext_count_b, ext_count_a} & ~ext_d_r;

    genvar t;
    generate
        for (t = 0; t < NTM; t++) begin : g_tm
            wire [2:0] sel = tm_ctl_r[t][`CC_TCTL_SEL_MSB:`CC_TCTL_SEL_LSB];
            // finest prescale is 8 hclk = 16 units
            wire [`CC_PRE_W-1:0] pmask =
                `CC_PRE_W'((`CC_PRE_MIN << sel) - 1);
            wire pre_tick = ((pre_r & pmask) == pmask);
            // only first timers take the count pin
            wire src = (sel == `CC_SEL_GP_SIX) ? gp_timer_six_ovf :
                       (sel == `CC_SEL_EXT) ?
                           ((t % 2 == 0) & ext_rise[t/2]) : pre_tick;
            wire tick = tm_ctl_r[t][`CC_TCTL_RUN_BIT] & src;

            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    tm_ctl_r[t] <= `CC_TCTL_RESET;
                end else if (wr_tctl && wtm == t) begin
                    tm_ctl_r[t] <= hwdata[3:0];
                end
            end

            capture_compare_unit_timebase u_tb (
                .hclk    (hclk),
                .hresetn (hresetn),
                .tick    (tick),
                .cnt_we  (wr_cnt && wtm == t),
                .rld_we  (wr_rld && wtm == t),
                .wdata   (hwdata[15:0]),
                .cnt     (tm_cnt[t]),
                .rld     (tm_rld[t]),
                .step    (tm_step[t]),
                .ovf     (tm_ovf[t])
            );
        end
    endgenerate

    // ---------------- channels ----------------
    logic [NCH-1:0] match;

    genvar i;
    generate
        for (i = 0; i < NCH; i++) begin : g_ch
            localparam bit LOWER = (i % 16) < 8;
            localparam int PART  = LOWER ? i + 8 : i - 8;
            localparam bit NODRV = (i >= 24) && (i <= 27);

            capture_compare_unit_pkg::mode_t mode;
            assign mode = ch_ctl_r[i][`CC_CTL_MODE_MSB:`CC_CTL_MODE_LSB];
            // timer chosen inside this channel's own pair
            wire [1:0] tix = {1'(i / 16), ch_ctl_r[i][`CC_CTL_TSEL_BIT]};
            wire       inp = cc_pin_in[i];
            wire       rise = inp & ~pin_in_d_r[i];
            wire       fall = ~inp & pin_in_d_r[i];
            wire edge_hit = (mode == `CC_MODE_CAP_RISE) ? rise :
                            (mode == `CC_MODE_CAP_FALL) ? fall :
                            (mode == `CC_MODE_CAP_BOTH) ? (rise | fall)
                                                        : 1'b0;
            // capture only when in a capture mode
            wire cap_hit = is_cap(mode) & edge_hit;
            assign match[i] = is_cmp(mode) & tm_step[tix] &
                              (tm_cnt[tix] == ch_val_r[i]);
            wire ovf = tm_ovf[tix];
            wire once = (mode == `CC_MODE_CMP2) |
                        (mode == `CC_MODE_CMP3);
            // once-per-period modes are gated by fired
            wire event_ok = match[i] & ~(once & fired_r[i]);
            wire dbl_own  = LOWER & ch_ctl_r[i][`CC_CTL_DBL_BIT];
            wire dbl_lost = !LOWER & ch_ctl_r[PART][`CC_CTL_DBL_BIT];
            wire dbl_tog  = dbl_own & (match[i] | match[PART]);

            // mode action on match
            // partner latch held: its pin is owned by the pair
            wire pin_nxt =
                dbl_own ? pin_r[i] ^ dbl_tog :
                dbl_lost ? pin_r[i] :
                (mode == `CC_MODE_CMP1) ? pin_r[i] ^ match[i] :
                // set on match wins over clear on overflow
                (mode == `CC_MODE_CMP3) ?
                    (event_ok | (pin_r[i] & ~ovf)) : pin_r[i];
            wire drive = dbl_own | (!dbl_lost &
                         ((mode == `CC_MODE_CMP1) |
                          (mode == `CC_MODE_CMP3)));

            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    ch_val_r[i]   <= `CC_CNT_RESET;
                    ch_ctl_r[i]   <= `CC_CTL_RESET;
                    pin_r[i]      <= 1'b0;
                    oe_r[i]       <= 1'b0;
                    pin_in_d_r[i] <= 1'b0;
                    fired_r[i]    <= 1'b0;
                    irq_r[i]      <= 1'b0;
                end else begin
                    pin_in_d_r[i] <= inp;
                    // capture wins over a bus write
                    if (cap_hit) begin
                        ch_val_r[i] <= tm_cnt[tix];
                    end else if (wr_val && wch == i) begin
                        ch_val_r[i] <= hwdata[15:0];
                    end
                    if (wr_ctl && wch == i) begin
                        ch_ctl_r[i] <= hwdata[4:0];
                    end
                    // a match in the overflow cycle still counts
                    fired_r[i] <= match[i] | (fired_r[i] & ~ovf);
                    pin_r[i]   <= pin_nxt;
                    // pin drive, never on 24 to 27
                    oe_r[i]    <= drive & !NODRV;
                    irq_r[i]   <= cap_hit | event_ok;
                end
            end
        end
    endgenerate

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tirq_r <= 4'h0;
        end else begin
            tirq_r <= tm_ovf;
        end
    end

    assign cc_pin_out = pin_r;
    assign cc_pin_oe  = oe_r;
    assign ch_irq     = irq_r;
    assign tmr_irq    = tirq_r;
endmodule

// [hdl/capture_compare_unit_consts.svh]
// Purpose: constants of the dual time-base capture/compare unit
// Assumes: 32-bit AHB-Lite word registers, 250 MHz hclk
// Notes:   offsets are byte addresses
`ifndef CAPTURE_COMPARE_UNIT_CONSTS_SVH
`define CAPTURE_COMPARE_UNIT_CONSTS_SVH

`define CC_ADDR_W        12
`define CC_CH_VAL_BASE   12'h000
`define CC_CH_CTL_BASE   12'h080
`define CC_TMR_CNT_BASE  12'h100
`define CC_TMR_RLD_BASE  12'h110
`define CC_TMR_CTL_BASE  12'h120
`define CC_PIN_STATE     12'h130
`define CC_PIN_INPUT     12'h134

// channel control fields
`define CC_CTL_MODE_LSB  0
`define CC_CTL_MODE_MSB  2
`define CC_CTL_TSEL_BIT  3
`define CC_CTL_DBL_BIT   4
`define CC_CTL_RESET     5'h00

// channel modes
`define CC_MODE_OFF      3'h0
`define CC_MODE_CAP_RISE 3'h1
`define CC_MODE_CAP_FALL 3'h2
`define CC_MODE_CAP_BOTH 3'h3
`define CC_MODE_CMP0     3'h4
`define CC_MODE_CMP1     3'h5
`define CC_MODE_CMP2     3'h6
`define CC_MODE_CMP3     3'h7

// timer control fields
`define CC_TCTL_RUN_BIT  0
`define CC_TCTL_SEL_LSB  1
`define CC_TCTL_SEL_MSB  3
`define CC_TCTL_RESET    4'h0
`define CC_SEL_GP_SIX    3'h6
`define CC_SEL_EXT       3'h7

// timing: one timer-clock unit is half an hclk period
`define CC_HCLK_NS       4
`define CC_FINEST_TCL    16
`define CC_PRE_MIN       (`CC_FINEST_TCL / 2)
`define CC_PRE_W         11

`define CC_CNT_RESET     16'h0000
`define CC_CNT_MAX       16'hFFFF
`define CC_PIN_RESET     32'h0000_0000
`define CC_NO_DRIVE_MASK 32'h0F00_0000

`endif

// [hdl/capture_compare_unit_pkg.sv]
// Purpose: shared types of the capture/compare unit
// Assumes: constants come from capture_compare_unit_consts.svh
// Notes:   types only
package capture_compare_unit_pkg;
    typedef logic [15:0] count_t;
    typedef logic [2:0]  mode_t;
    typedef logic [2:0]  clk_sel_t;
endpackage

// [hdl/capture_compare_unit_timebase.sv]
// Purpose: one 16-bit reloadable time-base timer
// Assumes: tick is a one-cycle count enable
// Notes:   step and ovf follow the count update by nothing: same edge
`timescale 1ns/100ps
`include "capture_compare_unit_consts.svh"
module capture_compare_unit_timebase (
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              tick,
    input  wire logic              cnt_we,
    input  wire logic              rld_we,
    input  wire logic [15:0]       wdata,
    output capture_compare_unit_pkg::count_t     cnt,
    output capture_compare_unit_pkg::count_t     rld,
    output logic                   step,
    output logic                   ovf
);
    capture_compare_unit_pkg::count_t cnt_r;
    capture_compare_unit_pkg::count_t rld_r;
    logic               step_r;
    logic               ovf_r;

    wire at_top  = (cnt_r == `CC_CNT_MAX);
    wire advance = tick & ~cnt_we;
    wire [15:0] cnt_nxt = cnt_we ? wdata :
                          !advance ? cnt_r :
                          at_top ? rld_r : cnt_r + 16'h0001;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_r  <= `CC_CNT_RESET;
            rld_r  <= `CC_CNT_RESET;
            step_r <= 1'b0;
            ovf_r  <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            if (rld_we) begin
                rld_r <= wdata;
            end
            step_r <= advance;
            ovf_r  <= advance & at_top;
        end
    end

    assign cnt  = cnt_r;
    assign rld  = rld_r;
    assign step = step_r;
    assign ovf  = ovf_r;
endmodule

// [test/capture_compare_unit_properties.sv]
// Purpose: port-level checks of the capture/compare unit
// Assumes: one clock domain, zero-wait bus slave
// Notes:   bound to every instance of the top module
`timescale 1ns/100ps
`include "capture_compare_unit_consts.svh"
module capture_compare_unit_checker (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] cc_pin_out,
    input wire logic [31:0] cc_pin_oe,
    input wire logic [31:0] ch_irq,
    input wire logic [3:0]  tmr_irq
);
    logic rd_ap;
    logic dp_wr_r;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    assign rd_ap = hsel & htrans[1] & hready & ~hwrite;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            dp_wr_r <= 1'b0;
        else
            dp_wr_r <= hsel & htrans[1] & hready & hwrite;
    end
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("hresp is not OKAY");
    a_ready_high: assert property (hreadyout || $rose(hresetn))
        else $error("hreadyout low after reset");
    a_reset_quiet: assert property ($rose(hresetn) |-> ch_irq == 32'h0
        && tmr_irq == 4'h0 && cc_pin_oe == 32'h0 && hrdata == 32'h0)
        else $error("outputs not quiet after reset");
    a_no_drive: assert property (cc_pin_oe[27:24] == 4'h0)
        else $error("channels 24 to 27 drive their pins");
    a_oe_by_write: assert property ($changed(cc_pin_oe)
        |-> $past(dp_wr_r) || $past(dp_wr_r, 2))
        else $error("pin direction changed without a write");
    a_rdata_hold: assert property ($changed(hrdata) |-> $past(rd_ap))
        else $error("hrdata changed without a read");
    a_unmapped_zero: assert property (rd_ap && haddr[31:12] != 20'h0
        |=> hrdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_pin_state: assert property (rd_ap
        && haddr == {20'h0, `CC_PIN_STATE} |=> hrdata == $past(cc_pin_out))
        else $error("pin state read differs from pins");
endmodule
bind dual_timebase_capture_compare capture_compare_unit_checker u_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .cc_pin_out(cc_pin_out),
    .cc_pin_oe(cc_pin_oe), .ch_irq(ch_irq), .tmr_irq(tmr_irq));

// [test/pin_partner.sv]
// Purpose: port pins outside the capture/compare unit
// Assumes: unheld pins with no pull toggle every cycle
// Notes:   held pins follow the bench's level
`timescale 1ns/100ps
module pin_partner (
    input  wire logic        hclk,
    input  wire logic [31:0] hold_mask,
    input  wire logic [31:0] drive_lvl,
    input  wire logic [31:0] pin_out,
    input  wire logic [31:0] pin_oe,
    output logic      [31:0] pin_in
);
    logic [31:0] noise_r = 32'h5555_5555;
    logic [31:0] ext_lvl;
    always @(posedge hclk) begin
        noise_r <= ~noise_r;
    end
    assign ext_lvl = (hold_mask & drive_lvl) | (~hold_mask & noise_r);
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule

// [test/test_dual_timebase_capture_compare.sv]
// Purpose: self-checking bench of the capture/compare unit
// Assumes: zero-wait slave, but the master still waits on hready
// Notes:   reload and compare checks tick timers by timer-six pulses for exact counts
`timescale 1ns/100ps
`include "capture_compare_unit_consts.svh"
module test_dual_timebase_capture_compare;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic        ext_a = 1'b0;
    logic        ext_b = 1'b0;
    logic        gp = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] lvl = 32'h0000_0000;
    logic [31:0] hold = 32'h000E_0000;
    logic [31:0] seed = 32'h0001_81AD;
    logic [31:0] hrdata, cc_pin_in, cc_pin_out, cc_pin_oe, ch_irq;
    logic [31:0] eirq [4] = '{32'h0100_007C, 32'h4000, 32'h004C, 32'h0};
    logic [31:0] epin [4] = '{32'h0000_0064, 32'h24, 32'h0060, 32'h40};
    logic [15:0] rl [4];
    logic [3:0]  tmr_irq;
    logic        hreadyout, hresp;
    int          fail_count = 0, n_tests = 0, cyc = 0;

    dual_timebase_capture_compare u_dut (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .cc_pin_in(cc_pin_in),
        .cc_pin_out(cc_pin_out), .cc_pin_oe(cc_pin_oe), .ext_count_a(ext_a),
        .ext_count_b(ext_b), .gp_timer_six_ovf(gp), .ch_irq(ch_irq),
        .tmr_irq(tmr_irq));
    pin_partner u_pins (.hclk(hclk), .hold_mask(hold), .drive_lvl(lvl),
        .pin_out(cc_pin_out), .pin_oe(cc_pin_oe), .pin_in(cc_pin_in));

    always #2 hclk = ~hclk;

    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            complete_run();
        end
    end

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // capture fires on the chosen edge kind only
    function automatic logic cap_hit(input int m, input logic rise);
        return (m == 3) || ((m == 1) == rise);
    endfunction

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] s, e);
        n_tests++;
        if (s !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic bus(input logic w, input logic [31:0] a, d,
                       output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask

    task automatic wr(input logic [31:0] a, d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    // one timer-six pulse, then gather the request pulses
    task automatic pulse(output logic [31:0] s, output logic [3:0] t);
        @(posedge hclk);
        gp <= 1'b1;
        @(posedge hclk);
        gp <= 1'b0;
        s = 32'h0;
        t = 4'h0;
        repeat (6) begin
            @(posedge hclk);
            s = s | ch_irq;
            t = t | tmr_irq;
        end
    endtask

    task automatic pin_to(input int c, input logic b, output logic [31:0] s);
        @(posedge hclk);
        lvl[c] <= b;
        s = 32'h0;
        repeat (6) begin
            @(posedge hclk);
            s = s | ch_irq;
        end
    endtask

    initial begin
        logic [31:0] v, q, s, x, v1, v2;
        logic [3:0]  t;
        int          chs [7] = '{2, 3, 4, 5, 6, 14, 24};
        logic [7:0]  cts [7] = '{8'h0D, 8'h0C, 8'h0E, 8'h0F, 8'h1D, 8'h0D,
                                 8'h05};
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        chk("hreadyout", {31'h0, hreadyout}, 32'h1);
        chk("pin_oe", cc_pin_oe, 32'h0);
        for (int k = 0; k < 32; k++) begin
            v = xs();
            wr(`CC_CH_VAL_BASE + 4 * k, v);
            bus(1'b0, `CC_CH_VAL_BASE + 4 * k, 32'h0, q);
            chk("ch_value", q, {16'h0, v[15:0]});
        end
        wr(32'h0000_1000, xs());
        bus(1'b0, 32'h0000_1000, 32'h0, q);
        chk("unmapped", q, 32'h0);
        for (int k = 0; k < 4; k++) begin
            v = xs();
            rl[k] = v[15:0] | 16'h8000;
            wr(`CC_TMR_RLD_BASE + 4 * k, rl[k]);
            wr(`CC_TMR_CNT_BASE + 4 * k, 32'h0000_FFFF);
            wr(`CC_TMR_CTL_BASE + 4 * k, 32'h0000_000D);
        end
        pulse(s, t);
        chk("tmr_irq", {28'h0, t}, 32'h0000_000F);
        for (int k = 0; k < 4; k++) begin
            bus(1'b0, `CC_TMR_CNT_BASE + 4 * k, 32'h0, q);
            chk("reload", q, {16'h0, rl[k]});
        end
        // prescaler phase is free running, so one tick of slack
        wr(`CC_TMR_CNT_BASE + 4, 32'h0);
        wr(`CC_TMR_CTL_BASE + 4, 32'h1);
        repeat (80) @(posedge hclk);
        wr(`CC_TMR_CTL_BASE + 4, 32'h0);
        bus(1'b0, `CC_TMR_CNT_BASE + 4, 32'h0, q);
        chk("prescale", {31'h0, q == 32'd10 || q == 32'd11}, 32'h1);
        wr(`CC_TMR_CTL_BASE, 32'hF);
        wr(`CC_TMR_CTL_BASE + 8, 32'hF);
        wr(`CC_TMR_CNT_BASE, 32'h0);
        wr(`CC_TMR_CNT_BASE + 8, 32'h0);
        repeat (5) begin
            @(posedge hclk);
            ext_a <= 1'b1;
            ext_b <= 1'b1;
            repeat (3) @(posedge hclk);
            ext_a <= 1'b0;
            ext_b <= 1'b0;
            repeat (3) @(posedge hclk);
        end
        bus(1'b0, `CC_TMR_CNT_BASE, 32'h0, q);
        chk("ext_a", q, 32'h5);
        bus(1'b0, `CC_TMR_CNT_BASE + 8, 32'h0, q);
        chk("ext_b", q, 32'h5);
        for (int m = 1; m < 4; m++) begin
            v1 = xs() & 32'h0000_FFFF;
            v2 = xs() & 32'h0000_FFFF;
            wr(`CC_CH_CTL_BASE + 4 * (16 + m), m | 8);
            wr(`CC_TMR_CNT_BASE + 12, v1);
            pin_to(16 + m, 1'b1, s);
            chk("cap_rise", {31'h0, s[16 + m]}, {31'h0, cap_hit(m, 1)});
            wr(`CC_TMR_CNT_BASE + 12, v2);
            pin_to(16 + m, 1'b0, s);
            chk("cap_fall", {31'h0, s[16 + m]}, {31'h0, cap_hit(m, 0)});
            bus(1'b0, `CC_CH_VAL_BASE + 4 * (16 + m), 32'h0, q);
            chk("cap_value", q, (m == 1) ? v1 : v2);
        end
        v = xs();
        x = {20'h1, v[11:0]};
        for (int i = 0; i < 7; i++) begin
            wr(`CC_CH_VAL_BASE + 4 * chs[i], (chs[i] == 14) ? x + 1 : x);
            wr(`CC_CH_CTL_BASE + 4 * chs[i], {24'h0, cts[i]});
        end
        wr(`CC_TMR_CNT_BASE + 8, x - 1);
        wr(`CC_TMR_CTL_BASE + 4, 32'hD);
        wr(`CC_TMR_CTL_BASE + 8, 32'hD);
        for (int p = 0; p < 4; p++) begin
            wr(`CC_TMR_CNT_BASE + 4, (p == 3) ? 32'h0000_FFFF : x - (p != 1));
            pulse(s, t);
            chk("cmp_irq", s & 32'h0100_407C, eirq[p]);
            chk("cmp_pin", cc_pin_out & 32'h407C, epin[p]);
        end
        chk("ovf_irq", {28'h0, t}, 32'h0000_0002);
        chk("cmp_oe", cc_pin_oe & 32'h0100_407C, 32'h64);
        bus(1'b0, {20'h0, `CC_PIN_STATE}, 32'h0, q);
        chk("pin_state", q & 32'h407C, 32'h0000_0040);
        complete_run();
    end
endmodule
